// File: include/mbcs_pkg.sv
// Package for the motor bypass contactor sequencer: register map, field
// positions, reset values, enumerations and packed structures.
// Assumes a 32-bit APB slave with byte addresses.
package mbcs_pkg;

    // Register byte offsets
    localparam logic [7:0] MBCS_CTRL_OFS   = 8'h00;
    localparam logic [7:0] MBCS_CFG_OFS    = 8'h04;
    localparam logic [7:0] MBCS_STATUS_OFS = 8'h08;
    localparam logic [7:0] MBCS_FREQ_OFS   = 8'h0c;

    // Control register fields
    localparam int CTRL_BYPASS_CMD_BIT  = 0;
    localparam int CTRL_ON_BIT          = 1;
    localparam int CTRL_NORMAL_OFF_BIT  = 2;
    localparam int CTRL_COAST_STOP_BIT  = 3;
    localparam int CTRL_QUICK_STOP_BIT  = 4;
    localparam int CTRL_OVP_EN_BIT      = 5;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_001c;

    // Configuration register fields
    localparam int CFG_MODE_LSB         = 0;  // bypass_mode_sel, 2 bits
    localparam int CFG_CTRL_MODE_LSB    = 4;  // control_mode_sel, 5 bits
    localparam int CFG_AUTO_RESTART_LSB = 12; // auto_restart_mode, 3 bits
    localparam int CFG_FLYING_BIT       = 16; // flying_restart_mode
    localparam int CFG_SYNC_EN_BIT      = 17; // synchronizer_enable
    localparam int CFG_SYNC_SRC_BIT     = 18; // synchronizer_trigger_src
    localparam int CFG_INDUCTION_BIT    = 19;
    localparam int CFG_SIGNAL_TRIG_BIT  = 20;
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;

    // Status register fields
    localparam int STAT_STATE_LSB       = 0;  // 4 bits
    localparam int STAT_PU_CMD_BIT      = 4;
    localparam int STAT_LINE_CMD_BIT    = 5;
    localparam int STAT_SYNC_REQ_BIT    = 6;
    localparam int STAT_PULSE_INH_BIT   = 7;
    localparam int STAT_PU_FB_BIT       = 8;
    localparam int STAT_LINE_FB_BIT     = 9;
    localparam int STAT_PERMIT_BIT      = 10;
    localparam int STAT_TEMP_MON_BIT    = 11;

    // Documented selector values
    localparam logic [1:0] MODE_SYNC_OVERLAP   = 2'h1;
    localparam logic [4:0] CTRL_MODE_SLESS     = 5'h14; // 20
    localparam logic [4:0] CTRL_MODE_VF_MAX    = 5'h13; // 19
    localparam logic [2:0] AUTO_RESTART_BYPASS = 3'h4;
    localparam int         FREQ_W              = 16;

    typedef enum {
        ST_IDLE,        // Pulses inhibited, motor off line
        ST_CONV_RUN,    // Motor on converter
        ST_SYNC_TO_LINE,
        ST_WAIT_LINE_FB,
        ST_RDY_OP_BYP,  // Ready for operation and bypass
        ST_RDY_ST_BYP,  // Ready to start and bypass
        ST_SYNC_FROM_LINE,
        ST_WAIT_PU_FB,
        ST_COAST
    } mbcs_state_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] cfg;
    } mbcs_regs_t;

    typedef struct packed {
        logic power_unit_contactor_cmd;
        logic line_contactor_cmd;
        logic synchronizing_request;
        logic pulse_inhibit;
        logic temp_monitor_active;
    } mbcs_outs_t;

endpackage

// File: hw/mbcs_sequencer.sv
// Motor bypass contactor sequencer with APB register access.
// Assumes contactor feedbacks, sync flag and DC-link comparator arrive
// asynchronously from pins; APB runs on pclk.
//
// Overview of operation
// R1: Drive power-unit and line contactor commands; read both contactor feedbacks.
// R2: Coast-stop or quick-stop withdrawn opens bypass; motor coasts down.
// R3: Normal off withdrawn in bypass keeps the line contactor closed.
// R4: After power-on, enter ready-to-start-and-bypass only with signal trigger, command, restart 4.
// R5: Power-up bypass entry takes priority over automatic restart switch-on.
// R6: Temperature monitoring active in both bypass ready states.
// R7: Bypass permitted only for induction motor, control mode 20 or 0..19.
// R8: Mode 1 overlaps both contactors closed during each changeover.
// R9: Overlapping bypass triggered only by the bypass control signal.
// R10: At DC-link maximum with protection on, inhibit pulses, only if flying restart 1. Code inhibits only while the power-unit contactor is commanded closed.
// R11: Bypass command with converter running raises synchronizing request.
// R12: Sync reached flag closes the line contactor internally.
// R13: Line feedback closed then open power-unit contactor, inhibit pulses.
// R14: On command withdrawn on line moves to ready-to-start-and-bypass.
// R15: Bypass withdrawn raises sync request before enabling pulses to retrieve.
// R16: During retrieval, sync reached closes the power-unit contactor.
// R17: Power-unit feedback closed then open line contactor, run on converter.
// R18: Outside controller interlocks bypass switch if drive powers down fully.
// R19: Overlap needs synchronizer enable 1 and trigger from the sync request.
// R20: Sync target frequency reported unsigned, without phase direction.
// R21: Flying restart recommended since pulses may enable with motor rotating.
// R22: Sync request clears after each completed handover.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module mbcs_sequencer
    import mbcs_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      power_unit_contactor_fb,
    input  wire logic                      line_contactor_fb,
    input  wire logic                      sync_reached_flag,
    input  wire logic                      dc_link_at_max,
    input  wire logic [mbcs_pkg::FREQ_W-1:0] sync_target_freq_in,
    output logic                           power_unit_contactor_cmd,
    output logic                           line_contactor_cmd,
    output logic                           synchronizing_request,
    output logic                           pulse_inhibit,
    output logic                           temp_monitor_active
);
    import mbcs_pkg::*;

    // Whole module state
    typedef struct packed {
        mbcs_regs_t                 regs;
        mbcs_state_t                st;
        mbcs_outs_t                 outs;
        logic [1:0]                 pu_fb_sync;
        logic [1:0]                 line_fb_sync;
        logic [1:0]                 sync_sync;
        logic [1:0]                 vdc_sync;
        logic                       bypass_cmd_q;
        logic                       powerup_eval;
        logic [FREQ_W-1:0]          freq;
        logic [31:0]                prdata;
        logic                       pready;
        logic                       pslverr;
    } mbcs_all_t;

    mbcs_all_t s_r;
    mbcs_all_t s_nxt;

    logic pu_fb;
    logic line_fb;
    logic sync_ok;
    logic vdc_max;
    logic bypass_cmd;
    logic on_cmd;
    logic coast_ok;
    logic quick_ok;
    logic normal_off_ok;
    logic permit;
    logic ovp_armed;
    logic [4:0] ctrl_mode;
    logic apb_acc;
    logic apb_wr;

    // Second stage only is read; first stage is left to settle [R1]
    assign pu_fb   = s_r.pu_fb_sync[1];
    assign line_fb = s_r.line_fb_sync[1];
    assign sync_ok = s_r.sync_sync[1];
    assign vdc_max = s_r.vdc_sync[1];

    // Decoded control and configuration fields
    assign bypass_cmd    = s_r.regs.ctrl[CTRL_BYPASS_CMD_BIT];
    assign on_cmd        = s_r.regs.ctrl[CTRL_ON_BIT];
    assign normal_off_ok = s_r.regs.ctrl[CTRL_NORMAL_OFF_BIT];
    assign coast_ok      = s_r.regs.ctrl[CTRL_COAST_STOP_BIT];
    assign quick_ok      = s_r.regs.ctrl[CTRL_QUICK_STOP_BIT];
    assign ctrl_mode     = s_r.regs.cfg[CFG_CTRL_MODE_LSB +: 5];
    assign apb_acc       = psel && penable && !s_r.pready;
    assign apb_wr        = psel && penable && pwrite && s_r.pready;

    // Bypass allowed only in overlap mode with synchronizer set up [R7] [R19]
    assign permit = s_r.regs.cfg[CFG_INDUCTION_BIT]
                 && (ctrl_mode == CTRL_MODE_SLESS || ctrl_mode <= CTRL_MODE_VF_MAX)
                 && s_r.regs.cfg[CFG_MODE_LSB +: 2] == MODE_SYNC_OVERLAP
                 && s_r.regs.cfg[CFG_SYNC_EN_BIT]
                 && s_r.regs.cfg[CFG_SYNC_SRC_BIT];

    // Overvoltage guard needs flying restart, since the motor then coasts [R10] [R21]
    assign ovp_armed = s_r.regs.ctrl[CTRL_OVP_EN_BIT] && s_r.regs.cfg[CFG_FLYING_BIT];

    // Next-state logic: APB, synchronisers and the sequencer
    always_comb begin
        s_nxt = s_r;
        s_nxt.pu_fb_sync   = {s_r.pu_fb_sync[0], power_unit_contactor_fb};
        s_nxt.line_fb_sync = {s_r.line_fb_sync[0], line_contactor_fb};
        s_nxt.sync_sync    = {s_r.sync_sync[0], sync_reached_flag};
        s_nxt.vdc_sync     = {s_r.vdc_sync[0], dc_link_at_max};
        s_nxt.bypass_cmd_q = bypass_cmd;
        // Unsigned magnitude only; phase order must be matched in wiring [R20]
        s_nxt.freq         = sync_target_freq_in;

        // APB slave: one wait state, answer in the second access cycle
        s_nxt.pready  = apb_acc;
        s_nxt.pslverr = 1'b0;
        if (apb_acc) begin
            s_nxt.prdata = 32'h0000_0000;
            case (paddr)
                MBCS_CTRL_OFS: begin
                    s_nxt.prdata = s_r.regs.ctrl;
                end
                MBCS_CFG_OFS: begin
                    s_nxt.prdata = s_r.regs.cfg;
                end
                MBCS_STATUS_OFS: begin
                    s_nxt.prdata[STAT_STATE_LSB +: 4] = 4'(s_r.st);
                    s_nxt.prdata[STAT_PU_CMD_BIT]     = s_r.outs.power_unit_contactor_cmd;
                    s_nxt.prdata[STAT_LINE_CMD_BIT]   = s_r.outs.line_contactor_cmd;
                    s_nxt.prdata[STAT_SYNC_REQ_BIT]   = s_r.outs.synchronizing_request;
                    s_nxt.prdata[STAT_PULSE_INH_BIT]  = s_r.outs.pulse_inhibit;
                    s_nxt.prdata[STAT_PU_FB_BIT]      = pu_fb;
                    s_nxt.prdata[STAT_LINE_FB_BIT]    = line_fb;
                    s_nxt.prdata[STAT_PERMIT_BIT]     = permit;
                    s_nxt.prdata[STAT_TEMP_MON_BIT]   = s_r.outs.temp_monitor_active;
                    s_nxt.pslverr                     = pwrite;
                end
                MBCS_FREQ_OFS: begin
                    s_nxt.prdata[FREQ_W-1:0] = s_r.freq;
                    s_nxt.pslverr            = pwrite;
                end
                default: begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // Write lands at the completing edge, where the master sees pready
        if (apb_wr && paddr == MBCS_CTRL_OFS) begin
            s_nxt.regs.ctrl = {26'h0, pwdata[5:0]};
        end
        if (apb_wr && paddr == MBCS_CFG_OFS) begin
            s_nxt.regs.cfg = pwdata & 32'h001f_71f3;
        end

        // Sequencer
        case (s_r.st)
            ST_IDLE: begin
                s_nxt.outs.pulse_inhibit = 1'b1;
                // Configuration comes up cleared, so recovery is weighed until first switch-on
                // Power-up bypass recovery beats restart switch-on [R4] [R5]
                if (s_r.powerup_eval && line_fb && !pu_fb && permit && bypass_cmd
                    && s_r.regs.cfg[CFG_SIGNAL_TRIG_BIT]
                    && s_r.regs.cfg[CFG_AUTO_RESTART_LSB +: 3] == AUTO_RESTART_BYPASS) begin
                    s_nxt.powerup_eval = 1'b0;
                    s_nxt.outs.line_contactor_cmd = 1'b1;
                    s_nxt.st = ST_RDY_ST_BYP;
                end else if (on_cmd && coast_ok && quick_ok && normal_off_ok) begin
                    s_nxt.powerup_eval = 1'b0;
                    s_nxt.outs.power_unit_contactor_cmd = 1'b1;
                    s_nxt.outs.pulse_inhibit = 1'b0;
                    s_nxt.st = ST_CONV_RUN;
                end
            end
            ST_CONV_RUN: begin
                if (!on_cmd || !normal_off_ok) begin
                    s_nxt.outs.pulse_inhibit = 1'b1;
                    s_nxt.outs.power_unit_contactor_cmd = 1'b0;
                    s_nxt.st = ST_IDLE;
                end else if (bypass_cmd && !s_r.bypass_cmd_q && permit && pu_fb) begin
                    // Only the control signal edge starts a transfer [R9] [R11]
                    s_nxt.outs.synchronizing_request = 1'b1;
                    s_nxt.st = ST_SYNC_TO_LINE;
                end
            end
            ST_SYNC_TO_LINE: begin
                if (sync_ok) begin
                    s_nxt.outs.line_contactor_cmd = 1'b1; // [R12]
                    s_nxt.st = ST_WAIT_LINE_FB;
                end
            end
            ST_WAIT_LINE_FB: begin
                // Both closed until line feedback proves the overlap [R8] [R13]
                if (line_fb) begin
                    s_nxt.outs.power_unit_contactor_cmd = 1'b0;
                    s_nxt.outs.pulse_inhibit = 1'b1;
                    s_nxt.outs.synchronizing_request = 1'b0; // [R22]
                    s_nxt.st = ST_RDY_OP_BYP;
                end
            end
            ST_RDY_OP_BYP: begin
                // Normal off leaves the motor on the line [R3] [R14]
                if (!on_cmd || !normal_off_ok) begin
                    s_nxt.st = ST_RDY_ST_BYP;
                end else if (!bypass_cmd) begin
                    // Request raised ahead of pulse enable means retrieval [R15]
                    s_nxt.outs.synchronizing_request = 1'b1;
                    s_nxt.st = ST_SYNC_FROM_LINE;
                end
            end
            ST_RDY_ST_BYP: begin
                if (on_cmd && normal_off_ok) begin
                    s_nxt.st = ST_RDY_OP_BYP;
                end
            end
            ST_SYNC_FROM_LINE: begin
                s_nxt.outs.pulse_inhibit = 1'b0; // One cycle after the request [R15]
                if (sync_ok && s_r.outs.synchronizing_request && !s_r.outs.pulse_inhibit) begin
                    s_nxt.outs.power_unit_contactor_cmd = 1'b1; // [R16]
                    s_nxt.st = ST_WAIT_PU_FB;
                end
            end
            ST_WAIT_PU_FB: begin
                if (pu_fb) begin
                    s_nxt.outs.line_contactor_cmd = 1'b0; // [R17]
                    s_nxt.outs.synchronizing_request = 1'b0; // [R22]
                    s_nxt.st = ST_CONV_RUN;
                end
            end
            ST_COAST: begin
                if (!on_cmd && coast_ok && quick_ok) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        // Overvoltage while the power-unit contactor is commanded closed: stop pulses, no further rise [R10]
        if (ovp_armed && vdc_max && s_r.outs.power_unit_contactor_cmd) begin
            s_nxt.outs.pulse_inhibit = 1'b1;
        end

        // Coast or quick stop opens everything in every mode [R2]
        if (!coast_ok || !quick_ok) begin
            s_nxt.outs.power_unit_contactor_cmd = 1'b0;
            s_nxt.outs.line_contactor_cmd = 1'b0;
            s_nxt.outs.synchronizing_request = 1'b0;
            s_nxt.outs.pulse_inhibit = 1'b1;
            s_nxt.st = ST_COAST;
        end

        // Temperature sensing stays live in both bypass ready states [R6]
        s_nxt.outs.temp_monitor_active = (s_nxt.st == ST_RDY_ST_BYP)
                                      || (s_nxt.st == ST_RDY_OP_BYP);
    end

    // State register; reset leaves pulses inhibited and contactors open
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r                    <= '0;
            s_r.regs.ctrl          <= CTRL_RESET;
            s_r.regs.cfg           <= CFG_RESET;
            s_r.st                 <= ST_IDLE;
            s_r.outs.pulse_inhibit <= 1'b1;
            s_r.powerup_eval       <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state flip-flops
    assign prdata                   = s_r.prdata;
    assign pready                   = s_r.pready;
    assign pslverr                  = s_r.pslverr;
    assign power_unit_contactor_cmd = s_r.outs.power_unit_contactor_cmd; // [R1]
    assign line_contactor_cmd       = s_r.outs.line_contactor_cmd; // [R1]
    assign synchronizing_request    = s_r.outs.synchronizing_request;
    assign pulse_inhibit            = s_r.outs.pulse_inhibit;
    assign temp_monitor_active      = s_r.outs.temp_monitor_active;

endmodule

`default_nettype wire

// File: test/mbcs_sequencer_checker.sv
// Pin-level assertions for the bypass contactor sequencer.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module mbcs_sequencer_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic power_unit_contactor_fb,
    input wire logic line_contactor_fb,
    input wire logic sync_reached_flag,
    input wire logic power_unit_contactor_cmd,
    input wire logic line_contactor_cmd,
    input wire logic synchronizing_request,
    input wire logic pulse_inhibit,
    input wire logic temp_monitor_active
);
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // APB access phase and the steps of the two overlapping changeovers
    sequence s_take;
        psel && penable && !pready;
    endsequence
    sequence s_line_in;
        $rose(line_contactor_cmd) && power_unit_contactor_cmd;
    endsequence
    sequence s_pu_out;
        $fell(power_unit_contactor_cmd) && line_contactor_cmd;
    endsequence
    sequence s_pu_in;
        $rose(power_unit_contactor_cmd) && line_contactor_cmd;
    endsequence
    sequence s_line_out;
        $fell(line_contactor_cmd) && power_unit_contactor_cmd;
    endsequence

    // Feedback goes through two sync stages, hence depth 2
    AST_LINE_CLOSE: assert property (s_line_in |->
        synchronizing_request && $past(sync_reached_flag, 2)) else $error("line closed early");
    AST_PU_OPEN: assert property (s_pu_out |->
        pulse_inhibit && !synchronizing_request && $past(line_contactor_fb, 2))
        else $error("unit opened early");
    AST_PU_CLOSE: assert property (s_pu_in |->
        synchronizing_request && !pulse_inhibit && $past(sync_reached_flag, 2))
        else $error("unit closed early");
    AST_LINE_OPEN: assert property (s_line_out |->
        !synchronizing_request && !pulse_inhibit && $past(power_unit_contactor_fb, 2))
        else $error("line opened early");
    AST_SYNC_FIRST: assert property ($fell(pulse_inhibit) && line_contactor_cmd |->
        $past(synchronizing_request)) else $error("pulses before sync");
    AST_TEMP_MON: assert property (temp_monitor_active == (line_contactor_cmd
        && !power_unit_contactor_cmd && pulse_inhibit && !synchronizing_request))
        else $error("temp monitor wrong");
    AST_INHIBIT: assert property (!power_unit_contactor_cmd && !synchronizing_request |->
        pulse_inhibit) else $error("pulses without unit");
    AST_APB_ANSWER: assert property (s_take |=> pready) else $error("no ready");
    AST_APB_PULSE: assert property (pready |=> !pready) else $error("ready too long");
    AST_APB_ERR: assert property (pslverr |-> pready) else $error("stray error");
endmodule

bind mbcs_sequencer mbcs_sequencer_checker mbcs_sequencer_checker_inst (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .power_unit_contactor_fb,
    .line_contactor_fb, .sync_reached_flag, .power_unit_contactor_cmd, .line_contactor_cmd,
    .synchronizing_request, .pulse_inhibit, .temp_monitor_active);
`default_nettype wire

// File: test/mbcs_contactor_model.sv
// Contactor pair with feedback and a line synchronizer.
// Assumes registered command levels on pclk; feedback high means closed.
`timescale 1ns/1ps
`default_nettype none
module mbcs_contactor_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pu_cmd,
    input  wire logic line_cmd,
    input  wire logic sync_req,
    input  wire logic slow,
    input  wire logic hold_line,
    output logic      pu_fb,
    output logic      line_fb,
    output logic      sync_flag
);
    logic [3:0] c_pu, c_ln, c_sy, dly;
    // Slow contactors travel 13 cycles instead of 3
    assign dly = slow ? 4'hc : 4'h2;
    // Each feedback follows its command dly+1 cycles later; hold_line keeps line feedback closed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {c_pu, c_ln, c_sy, pu_fb, sync_flag} <= '0;
            line_fb <= hold_line; // Line closed by outside interlock
        end else begin
            c_pu <= (pu_fb == pu_cmd || c_pu == dly) ? 4'h0 : c_pu + 4'h1;
            c_ln <= (line_fb == line_cmd || c_ln == dly) ? 4'h0 : c_ln + 4'h1;
            c_sy <= (!sync_req || c_sy == dly) ? 4'h0 : c_sy + 4'h1;
            if (c_pu == dly)
                pu_fb <= pu_cmd;
            if (c_ln == dly)
                line_fb <= line_cmd | hold_line;
            // Match only while the request stands
            if (!sync_req)
                sync_flag <= 1'b0;
            else if (c_sy == dly)
                sync_flag <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the bypass contactor sequencer.
// Assumes the contactor model stands on the pins and APB runs on pclk.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mbcs_pkg::*;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] e;
        logic        err;
    } mbcs_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        pu_fb, line_fb, sync_flag, dc_max, slow, hold_line;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    wire mbcs_outs_t outs;
    mbcs_row_t   rows [18];
    int          n_errors, samples_checked, cycles, ovl;

    mbcs_sequencer mbcs_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_unit_contactor_fb(pu_fb),
        .line_contactor_fb(line_fb), .sync_reached_flag(sync_flag), .dc_link_at_max(dc_max),
        .sync_target_freq_in(16'h8abc), .power_unit_contactor_cmd(outs.power_unit_contactor_cmd),
        .line_contactor_cmd(outs.line_contactor_cmd), .pulse_inhibit(outs.pulse_inhibit),
        .synchronizing_request(outs.synchronizing_request),
        .temp_monitor_active(outs.temp_monitor_active));
    mbcs_contactor_model mbcs_contactor_model_inst (.pclk(pclk), .presetn(presetn),
        .pu_cmd(outs.power_unit_contactor_cmd), .line_cmd(outs.line_contactor_cmd),
        .sync_req(outs.synchronizing_request), .slow(slow), .hold_line(hold_line),
        .pu_fb(pu_fb), .line_fb(line_fb), .sync_flag(sync_flag));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Overlap counter and hang guard
    always @(posedge pclk) begin
        ovl += int'(outs.power_unit_contactor_cmd && outs.line_contactor_cmd);
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Request held until ready is sampled; hang cut by the guard
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_outs(input mbcs_outs_t e);
        for (int n = 0; n < 80 && outs !== e; n++) @(posedge pclk);
        chk({27'h0, outs}, {27'h0, e});
    endtask
    task automatic rd_state(input logic [3:0] s);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd & 32'hf, {28'h0, s});
    endtask
    task automatic to_line();
        // Bypass is refused until the unit feedback has passed the syncs
        for (int n = 0; n < 80 && pu_fb !== 1'b1; n++) @(posedge pclk);
        repeat (3) @(posedge pclk);
        ovl = 0;
        apb(1'b1, 8'h00, 32'h1f);
        wait_outs(5'b10100);
        wait_outs(5'b01011);
        chk({31'h0, ovl != 0}, 32'h1);
    endtask
    task automatic retrieve();
        ovl = 0;
        apb(1'b1, 8'h00, 32'h1e);
        wait_outs(5'b01100);
        wait_outs(5'b10000);
        chk({31'h0, ovl != 0}, 32'h1);
    endtask

    initial begin
        {psel, penable, pwrite, dc_max, slow, hold_line, presetn} = '0;
        {paddr, pwdata, n_errors, samples_checked, cycles, ovl} = '0;
        rows = '{'{0, 8'h00, 0, '1, 32'h1c, 0}, '{0, 8'h04, 0, '1, 0, 0},
            '{0, 8'h08, 0, 32'hfff, 32'h80, 0}, '{0, 8'h0c, 0, '1, 32'h8abc, 0},
            '{1, 8'h08, 0, 0, 0, 1}, '{1, 8'h0c, 0, 0, 0, 1}, '{0, 8'h10, 0, '1, 0, 1},
            '{1, 8'h04, 32'h1e4151, 0, 0, 0}, '{0, 8'h08, 0, 32'h400, 0, 0},
            '{1, 8'h04, 32'h1e4131, 0, 0, 0}, '{0, 8'h08, 0, 32'h400, 32'h400, 0},
            '{1, 8'h04, 32'h164141, 0, 0, 0}, '{0, 8'h08, 0, 32'h400, 0, 0},
            '{1, 8'h04, 32'h1e4142, 0, 0, 0}, '{0, 8'h08, 0, 32'h400, 0, 0},
            '{1, 8'h04, 32'h1f4141, 0, 0, 0}, '{0, 8'h04, 0, 32'h1f71f3, 32'h1f4141, 0},
            '{0, 8'h08, 0, 32'h400, 32'h400, 0}};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[k]) begin
            apb(rows[k].w, rows[k].a, rows[k].d);
            chk({31'h0, er}, {31'h0, rows[k].err});
            if (!rows[k].w)
                chk(rd & rows[k].m, rows[k].e);
        end
        // Coast stop, then quick stop, each from the line; on, then normal off withdrawn
        for (int i = 3; i <= 4; i++) begin
            slow <= (i == 3);
            apb(1'b1, 8'h00, 32'h1e);
            wait_outs(5'b10000);
            to_line();
            apb(1'b1, 8'h00, 32'h1f & ~(32'h2 << (i - 3)));
            rd_state(4'h5);
            wait_outs(5'b01011);
            apb(1'b1, 8'h00, 32'h1f);
            rd_state(4'h4);
            retrieve();
            to_line();
            apb(1'b1, 8'h00, 32'h1f & ~(32'h1 << i));
            wait_outs(5'b00010);
            rd_state(4'h8);
            apb(1'b1, 8'h00, 32'h1c);
            rd_state(4'h0);
        end
        // Overvoltage guard: inert without flying restart
        apb(1'b1, 8'h04, 32'h1e4141);
        apb(1'b1, 8'h00, 32'h3e);
        wait_outs(5'b10000);
        dc_max <= 1'b1;
        repeat (10) @(posedge pclk);
        chk({27'h0, outs}, 32'h10);
        apb(1'b1, 8'h04, 32'h1f4141);
        wait_outs(5'b10010);
        // Power-up with line closed but configuration cleared
        dc_max <= 1'b0;
        hold_line <= 1'b1;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_state(4'h0);
        wait_outs(5'b00010);
        // Recovery configured: line kept, switch-on must lose
        apb(1'b1, 8'h04, 32'h1f4141);
        apb(1'b1, 8'h00, 32'h1f);
        wait_outs(5'b01011);
        rd_state(4'h4);
        conclude();
    end
endmodule
`default_nettype wire
